// File: rtl/usb_core_reset_gating_dma.v
// Control slice of a USB OTG core: soft reset, OUT endpoint handling, clock gate
// Functional notes
// - Soft reset clears global interrupt mask
// - Unmasked pending cause raises interrupt one clock later
// - Descriptor DMA: NAK OUT after completion
// - Disabled endpoint packet blocks shared FIFO
// - Multi-transfer keeps endpoint enabled after completion
// - Stop bit gates the PHY clock
// - Resume and session detection survive gating
// - Clearing stop bit removes gating
// - Host supports DMA and slave modes
// - DMA notifies CPU only at completion
`timescale 1ns/100ps
`default_nettype none
`include "usb_ctl_map.vh"
module usb_core_reset_gating_dma #(
  parameter EP_N = 4,
  parameter PKT_W = 8,
  parameter FIFO_AW = 3
) (
  input wire mclk,
  input wire reset,
  input wire [`ADDR_W-1:0] addr,
  input wire [31:0] wdata,
  input wire wr,
  input wire rd,
  output reg [31:0] rdata,
  output reg irq,
  // Token side of the OUT endpoints
  input wire out_token,
  input wire [1:0] out_ep,
  input wire [PKT_W-1:0] out_data,
  output reg out_ack,
  output reg out_nak,
  // Software drains the FIFO head
  input wire rx_pop,
  // Line events from the PHY, asynchronous
  input wire resume_pin,
  input wire session_req_pin,
  // Host DMA word traffic
  input wire host_dma_beat,
  input wire host_dma_last,
  output reg host_dma_active,
  output reg phy_clk_en
);
  reg [2:0] bus_cfg_q;
  reg soft_rst_q;
  reg [7:0] rst_cnt_q;
  reg [`IRQ_W-1:0] mask_q;
  reg [`IRQ_W-1:0] stat_q;
  reg stop_q;
  reg [EP_N-1:0] ep_en_q;
  reg [EP_N-1:0] ep_multi_transfer_keep_q;
  reg [EP_N-1:0] ep_xfer_q;
  reg [7:0] xfer_len_q;
  reg [2:0] res_s_q;
  reg [2:0] ses_s_q;
  reg res_lvl_q;
  reg ses_lvl_q;
  reg dma_busy_q;
  wire core_rst = reset | soft_rst_q;
  wire [PKT_W+1:0] fifo_head;
  wire fifo_empty;
  wire fifo_full;
  wire [1:0] head_ep = fifo_head[PKT_W+1:PKT_W];
  wire target_en = ep_en_q[out_ep];
  wire accept = out_token && !fifo_full && (target_en || !bus_cfg_q[`BIT_DESC_DMA]);
  // A parked packet for a disabled endpoint holds the head and blocks all others
  wire pop_ok = rx_pop && !fifo_empty && ep_en_q[head_ep];
  wire [EP_N-1:0] done_vec;
  wire res_rise = res_s_q[2] & res_s_q[1] & !res_lvl_q;
  wire ses_rise = ses_s_q[2] & ses_s_q[1] & !ses_lvl_q;
  wire host_done = bus_cfg_q[`BIT_HOST_DMA_MODE] && host_dma_beat && host_dma_last;
  wire [`IRQ_W-1:0] events;

  // Register strobe decode shared by the write strobes and the status read strobe
  function reg_hit;
    input strobe;
    input [`ADDR_W-1:0] a;
    input [`ADDR_W-1:0] idx;
    begin
      reg_hit = strobe && (a == idx);
    end
  endfunction

  wire wr_cfg = reg_hit(wr, addr, `OFF_BUS_CONFIG);
  wire wr_rst = reg_hit(wr, addr, `OFF_RESET_CONTROL);
  wire wr_mask = reg_hit(wr, addr, `OFF_IRQ_MASK_BITS);
  wire wr_gate = reg_hit(wr, addr, `OFF_POWER_CLOCK_GATE);
  wire wr_ep = reg_hit(wr, addr, `OFF_EP_CONTROL);
  wire rd_stat = reg_hit(rd, addr, `OFF_IRQ_STATUS);

  function [31:0] zext5;
    input [`IRQ_W-1:0] v;
    begin
      zext5 = {{(32-`IRQ_W){1'b0}}, v};
    end
  endfunction

  shared_rx_fifo #(
    .W(PKT_W + 2),
    .AW(FIFO_AW)
  ) u_fifo (
    .mclk(mclk),
    .clr(core_rst),
    .push(accept),
    .push_data({out_ep, out_data}),
    .pop(pop_ok),
    .head(fifo_head),
    .empty(fifo_empty),
    .full(fifo_full)
  );

  // Per-endpoint completion counters, each private to its endpoint
  genvar g;
  generate
    for (g = 0; g < EP_N; g = g + 1) begin : g_ep
      reg [7:0] cnt_q;
      wire head_here = pop_ok && (head_ep == g);
      assign done_vec[g] = head_here && (cnt_q == 8'h01);
      always @(posedge mclk) begin
        if (core_rst) begin
          cnt_q <= 8'h00;
        end else if (wr_ep && wdata[g]) begin
          cnt_q <= xfer_len_q;
        end else if (head_here && cnt_q != 8'h00) begin
          cnt_q <= cnt_q - 8'h01;
        end
      end
    end
  endgenerate

  assign events[`IRQ_XFER_DONE] = |done_vec;
  assign events[`IRQ_RESUME] = res_rise;
  assign events[`IRQ_SESSION_REQ] = ses_rise;
  assign events[`IRQ_RX_FULL] = fifo_full & out_token;
  assign events[`IRQ_HOST_DMA_DONE] = host_done;

  // Line detectors on the free-running system clock, never gated
  always @(posedge mclk) begin
    if (reset) begin
      res_s_q <= 3'h0;
      ses_s_q <= 3'h0;
      res_lvl_q <= 1'b0;
      ses_lvl_q <= 1'b0;
    end else begin
      res_s_q <= {res_s_q[1:0], resume_pin};
      ses_s_q <= {ses_s_q[1:0], session_req_pin};
      if (res_s_q[2] == res_s_q[1])
        res_lvl_q <= res_s_q[2];
      if (ses_s_q[2] == ses_s_q[1])
        ses_lvl_q <= ses_s_q[2];
    end
  end

  // Soft reset sequencer
  always @(posedge mclk) begin
    if (reset) begin
      soft_rst_q <= 1'b0;
      rst_cnt_q <= 8'h00;
    end else if (soft_rst_q) begin
      if (rst_cnt_q == 8'h01)
        soft_rst_q <= 1'b0;
      rst_cnt_q <= rst_cnt_q - 8'h01;
    end else if (wr_rst && wdata[`BIT_CORE_SOFT_RESET]) begin
      soft_rst_q <= 1'b1;
      rst_cnt_q <= `SOFT_RESET_CYCLES;
    end
  end

  // Configuration and endpoint control
  always @(posedge mclk) begin
    if (core_rst) begin
      bus_cfg_q <= 3'h0;
      mask_q <= {`IRQ_W{1'b0}};
      ep_en_q <= {EP_N{1'b0}};
      ep_multi_transfer_keep_q <= {EP_N{1'b0}};
      xfer_len_q <= 8'h01;
    end else begin
      if (wr_cfg)
        bus_cfg_q <= wdata[2:0];
      if (wr_mask)
        mask_q <= wdata[`IRQ_W-1:0];
      if (wr_ep) begin
        ep_en_q <= ep_en_q | wdata[EP_N-1:0];
        ep_multi_transfer_keep_q <= wdata[8+EP_N-1:8];
        xfer_len_q <= wdata[23:16];
      end else begin
        // Multi-transfer endpoints stay enabled and share the chain with software
        ep_en_q <= ep_en_q & ~(done_vec & ~ep_multi_transfer_keep_q);
      end
    end
  end

  // Clock stop lives outside the soft reset so a soft reset cannot wake the PHY
  always @(posedge mclk) begin
    if (reset) begin
      stop_q <= 1'b0;
      phy_clk_en <= 1'b1;
    end else begin
      if (wr_gate)
        stop_q <= wdata[`BIT_PHY_CLOCK_STOP];
      phy_clk_en <= !stop_q;
    end
  end

  // Status bits: set wins over the read that clears them
  always @(posedge mclk) begin
    if (core_rst) begin
      stat_q <= {`IRQ_W{1'b0}};
    end else if (rd_stat) begin
      stat_q <= events;
    end else begin
      stat_q <= stat_q | events;
    end
  end

  // Host DMA progress: CPU hears only of the last beat
  always @(posedge mclk) begin
    if (core_rst) begin
      dma_busy_q <= 1'b0;
    end else if (bus_cfg_q[`BIT_HOST_DMA_MODE] && host_dma_beat) begin
      dma_busy_q <= !host_dma_last;
    end
  end

  // Token answers
  always @(posedge mclk) begin
    if (core_rst) begin
      out_ack <= 1'b0;
      out_nak <= 1'b0;
      ep_xfer_q <= {EP_N{1'b0}};
    end else begin
      out_ack <= accept;
      out_nak <= out_token && !accept;
      ep_xfer_q <= ep_en_q;
    end
  end

  // Outputs and read port
  always @(posedge mclk) begin
    if (reset) begin
      irq <= 1'b0;
      host_dma_active <= 1'b0;
      rdata <= 32'h00000000;
    end else begin
      irq <= bus_cfg_q[`BIT_GLOBAL_IRQ_MASK] && |(stat_q & mask_q);
      host_dma_active <= dma_busy_q;
      rdata <= 32'h00000000;
      if (rd) begin
        case (addr)
          `OFF_BUS_CONFIG: rdata <= {29'h0, bus_cfg_q};
          `OFF_RESET_CONTROL: rdata <= {31'h0, soft_rst_q};
          `OFF_IRQ_MASK_BITS: rdata <= zext5(mask_q);
          `OFF_IRQ_STATUS: rdata <= zext5(stat_q);
          `OFF_POWER_CLOCK_GATE: rdata <= {31'h0, stop_q};
          `OFF_EP_CONTROL: rdata <= {8'h0, xfer_len_q, 4'h0, ep_multi_transfer_keep_q, 4'h0, ep_en_q};
          `OFF_EP_STATUS: rdata <= {24'h0, 4'h0, ep_xfer_q};
          `OFF_RX_STATUS: rdata <= {16'h0, 4'h0, fifo_full, fifo_empty, fifo_head};
          default: rdata <= 32'h00000000;
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// File: rtl/usb_ctl_map.vh
// Register offsets, field positions and timing counts of the USB control slice
`ifndef USB_CTL_MAP_VH
`define USB_CTL_MAP_VH
`define ADDR_W 4
`define OFF_BUS_CONFIG 4'h0
`define OFF_RESET_CONTROL 4'h1
`define OFF_IRQ_MASK_BITS 4'h2
`define OFF_IRQ_STATUS 4'h3
`define OFF_POWER_CLOCK_GATE 4'h4
`define OFF_EP_CONTROL 4'h5
`define OFF_EP_STATUS 4'h6
`define OFF_RX_STATUS 4'h7
`define BIT_GLOBAL_IRQ_MASK 0
`define BIT_HOST_DMA_MODE 1
`define BIT_DESC_DMA 2
`define BIT_CORE_SOFT_RESET 0
`define BIT_PHY_CLOCK_STOP 0
`define IRQ_XFER_DONE 0
`define IRQ_RESUME 1
`define IRQ_SESSION_REQ 2
`define IRQ_RX_FULL 3
`define IRQ_HOST_DMA_DONE 4
`define IRQ_W 5
`define SOFT_RESET_CYCLES 8'h08
`endif

// File: rtl/shared_rx_fifo.v
// Shared receive FIFO holding endpoint-tagged OUT packets
`timescale 1ns/100ps
`default_nettype none
module shared_rx_fifo #(
  parameter W = 12,
  parameter AW = 3
) (
  input wire mclk,
  input wire clr,
  input wire push,
  input wire [W-1:0] push_data,
  input wire pop,
  output wire [W-1:0] head,
  output wire empty,
  output wire full
);
  reg [W-1:0] mem [0:(1<<AW)-1];
  reg [AW:0] wp_q;
  reg [AW:0] rp_q;
  assign empty = (wp_q == rp_q);
  assign full = (wp_q[AW] != rp_q[AW]) && (wp_q[AW-1:0] == rp_q[AW-1:0]);
  assign head = mem[rp_q[AW-1:0]];
  always @(posedge mclk) begin
    if (push && !full)
      mem[wp_q[AW-1:0]] <= push_data;
  end
  always @(posedge mclk) begin
    if (clr) begin
      wp_q <= {(AW+1){1'b0}};
      rp_q <= {(AW+1){1'b0}};
    end else begin
      if (push && !full)
        wp_q <= wp_q + 1'b1;
      if (pop && !empty)
        rp_q <= rp_q + 1'b1;
    end
  end
endmodule
`default_nettype wire

// File: sim/usb_ctl_monitor.sv
// Port-level assertions for the USB control slice
`timescale 1ns/100ps
`default_nettype none
module usb_ctl_monitor (
  input wire logic mclk,
  input wire logic reset,
  input wire logic [3:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic irq,
  input wire logic out_token,
  input wire logic out_ack,
  input wire logic out_nak,
  input wire logic host_dma_beat,
  input wire logic host_dma_last,
  input wire logic host_dma_active,
  input wire logic phy_clk_en
);
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  wire gate_wr = wr && addr == 4'h4;
  chk_ans_excl: assert property (!(out_ack && out_nak))
    else $error("ack and nak together");
  chk_tok_answer: assert property (out_token |=> out_ack || out_nak)
    else $error("token left unanswered");
  chk_no_stray: assert property (!out_token |=> !out_ack && !out_nak)
    else $error("handshake without token");
  chk_gate_set: assert property (gate_wr && wdata[0] |-> ##[1:2] !phy_clk_en)
    else $error("clock not gated");
  chk_gate_clear: assert property (gate_wr && !wdata[0] |-> ##[1:2] phy_clk_en)
    else $error("clock not ungated");
  chk_gate_hold: assert property (!phy_clk_en && !gate_wr && !$past(gate_wr) |=> !phy_clk_en)
    else $error("gate released by itself");
  chk_dma_busy: assert property (host_dma_beat && !host_dma_last ##1
    host_dma_beat && !host_dma_last |-> ##1 host_dma_active)
    else $error("dma not active");
  chk_dma_idle: assert property (host_dma_beat && host_dma_last |-> ##2 !host_dma_active)
    else $error("dma still active");
  chk_soft_irq: assert property (wr && addr == 4'h1 && wdata[0] |-> ##9 !irq)
    else $error("irq after soft reset");
endmodule
bind usb_core_reset_gating_dma usb_ctl_monitor u_usb_ctl_monitor (.mclk, .reset, .addr,
  .wdata, .wr, .irq, .out_token, .out_ack, .out_nak, .host_dma_beat, .host_dma_last,
  .host_dma_active, .phy_clk_en);
`default_nettype wire

// File: sim/usb_host_model.sv
// Far-side USB host model offering OUT packets
`timescale 1ns/100ps
`default_nettype none
module usb_host_model (
  input wire logic mclk,
  input wire logic send,
  input wire logic [1:0] ep,
  input wire logic [7:0] data,
  output logic out_token = 1'b0,
  output logic [1:0] out_ep = 2'h0,
  output logic [7:0] out_data = 8'h0
);
  // Idle ep and data lines toggle so stale values never look valid
  always @(posedge mclk) begin
    out_token <= send;
    out_ep <= send ? ep : ~out_ep;
    out_data <= send ? data : ~out_data;
  end
endmodule
`default_nettype wire

// File: sim/usb_core_reset_gating_dma_tb.sv
// Self-checking bench of the USB control slice
`timescale 1ns/100ps
`default_nettype none
module usb_core_reset_gating_dma_tb;
  logic mclk = 0, reset = 1, wr = 0, rd = 0, rx_pop = 0, send = 0;
  logic resume_pin = 0, session_req_pin = 0, host_dma_beat = 0, host_dma_last = 0;
  logic [3:0] addr = 4'h0;
  logic [31:0] wdata = 32'h0, rdata;
  logic [1:0] sep = 2'h0, out_ep;
  logic [7:0] sdat = 8'h0, out_data;
  logic irq, out_token, out_ack, out_nak, host_dma_active, phy_clk_en;
  int n_errors = 0, total_checks = 0, cyc = 0;
  always #5 mclk = ~mclk;
  usb_core_reset_gating_dma u_usb_core_reset_gating_dma (.mclk, .reset, .addr, .wdata,
    .wr, .rd, .rdata, .irq, .out_token, .out_ep, .out_data, .out_ack, .out_nak, .rx_pop,
    .resume_pin, .session_req_pin, .host_dma_beat, .host_dma_last, .host_dma_active,
    .phy_clk_en);
  usb_host_model u_usb_host_model (.mclk, .send, .ep(sep), .data(sdat), .out_token,
    .out_ep, .out_data);
  task final_report;
    $display("errors %0d checks %0d", n_errors, total_checks);
    if (n_errors == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  function automatic logic [31:0] irq_exp(input logic glb, input logic [4:0] msk,
    input logic [4:0] st);
    return {31'h0, glb && |(msk & st)};
  endfunction
  task wreg(input logic [3:0] a, input logic [31:0] d);
    @(posedge mclk) {addr, wdata, wr} <= {a, d, 1'b1};
    @(posedge mclk) wr <= 0;
  endtask
  task rreg(input logic [3:0] a, output logic [31:0] q);
    @(posedge mclk) {addr, rd} <= {a, 1'b1};
    @(posedge mclk) rd <= 0;
    #1 q = rdata;
  endtask
  task tok(input logic [1:0] e, input logic ack);
    @(posedge mclk) {send, sep, sdat} <= {1'b1, e, 8'($urandom)};
    @(posedge mclk) send <= 0;
    @(posedge mclk) #1 chk({out_ack, out_nak}, {ack, !ack});
  endtask
  task pop;
    @(posedge mclk) rx_pop <= 1;
    @(posedge mclk) rx_pop <= 0;
  endtask
  task settle;
    repeat (10) @(posedge mclk);
    #1;
  endtask
  always @(posedge mclk) if (++cyc == 5000) begin
    n_errors++;
    final_report;
  end
  initial begin
    logic [31:0] q;
    q = $urandom(32'hB7BCC6C8);
    repeat (12) @(posedge mclk);
    reset <= 0;
    wreg(4'h8, $urandom);
    rreg(4'h8, q); chk(q, 0);
    wreg(4'h2, 32'h1F); wreg(4'h0, 32'h1);
    resume_pin <= 1; settle; chk(irq, irq_exp(1, 5'h1F, 5'h02));
    rreg(4'h3, q); chk(q[1], 1);
    settle; chk(irq, irq_exp(1, 5'h1F, 5'h00));
    wreg(4'h2, 32'h0); session_req_pin <= 1; settle; chk(irq, irq_exp(1, 5'h00, 5'h04));
    rreg(4'h3, q); chk(q[2], 1);
    {resume_pin, session_req_pin} <= 2'b00;
    wreg(4'h4, 32'h1); @(posedge mclk) #1 chk(phy_clk_en, 0);
    resume_pin <= 1; settle; rreg(4'h3, q); chk(q[1], 1);
    wreg(4'h4, 32'h0);
    @(posedge mclk) #1 chk(phy_clk_en, 1);
    resume_pin <= 0;
    wreg(4'h2, 32'h1F); wreg(4'h0, 32'h1); wreg(4'h1, 32'h1);
    rreg(4'h1, q); chk(q[0], 1);
    settle; rreg(4'h1, q); chk(q[0], 0);
    rreg(4'h0, q); chk(q[0], 0);
    wreg(4'h0, 32'h0);
    wreg(4'h2, 32'h1F); resume_pin <= 1; settle; chk(irq, irq_exp(0, 5'h1F, 5'h02));
    wreg(4'h0, 32'h4);
    wreg(4'h5, 32'h10001); tok(0, 1); pop;
    rreg(4'h6, q); chk(q[0], 0); tok(0, 0);
    wreg(4'h5, 32'h10202); tok(1, 1); pop;
    rreg(4'h6, q); chk(q[1], 1); tok(1, 1);
    wreg(4'h0, 32'h0); tok(2, 1); pop; pop;
    rreg(4'h7, q); chk(q[9:8], 2);
    repeat (7) tok(2'($urandom_range(3)), 1);
    tok(3, 0); rreg(4'h7, q); chk(q[11], 1);
    wreg(4'h2, 32'h10); wreg(4'h0, 32'h3);
    @(posedge mclk) host_dma_beat <= 1;
    repeat ($urandom_range(5, 2)) @(posedge mclk);
    #1 chk(irq, irq_exp(1, 5'h10, 5'h0B));
    @(posedge mclk) host_dma_last <= 1;
    @(posedge mclk) {host_dma_beat, host_dma_last} <= 2'b00;
    settle; chk(irq, irq_exp(1, 5'h10, 5'h1B));
    rreg(4'h3, q); chk(q[4], 1);
    wreg(4'h0, 32'h1);
    final_report;
  end
endmodule
`default_nettype wire
